// file: vmx_err_consts.svh
// Offsets, field positions, reset values and counts of the error unit.
`ifndef VMX_ERR_CONSTS_SVH
`define VMX_ERR_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define VE_REG_CTRL 8'h00
`define VE_REG_EXCMAP 8'h04
`define VE_REG_STATUS 8'h08
`define VE_REG_MASK 8'h0C
`define VE_REG_EXITINFO 8'h10
`define VE_REG_ABORTIND 8'h14

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define VE_CTRL_MCE 0
`define VE_CTRL_ENTRY_RELOAD 1
`define VE_CTRL_EXIT_ABORT 2

// Exception bitmap bit that routes the machine check exception.
`define VE_MC_VECTOR 5'h12

// ----------------------------------------------------------------------
// Status and mask fields
// ----------------------------------------------------------------------
`define VE_ST_ABORT 0
`define VE_ST_SHUTDOWN 1
`define VE_ST_MCDELIVER 2
`define VE_ST_EXITDONE 3
`define VE_ST_MCSEEN 4
`define VE_ST_BITS 5

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define VE_CTRL_RST 32'h0000_0000
`define VE_EXCMAP_RST 32'h0000_0000
`define VE_MASK_RST 32'h0000_0000
`define VE_HOST_LOAD_CYC 4

`endif

// file: vmx_err_pkg.sv
// Types shared by the virtualization error handling unit.
package vmx_err_pkg;

   // Main sequencer states, one-hot.
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_LOAD = 4'b0010,
      ST_ABORT = 4'b0100,
      ST_SHUT = 4'b1000
   } ve_state_t;

   // Treatment chosen for a recognised machine check.
   typedef enum logic [2:0] {
      ACT_EXC_HOST = 3'h0,
      ACT_EXC_GUEST = 3'h1,
      ACT_SHUT = 3'h2,
      ACT_RELOAD = 3'h3,
      ACT_ABORT = 3'h4,
      ACT_EXIT = 3'h5
   } mc_action_t;

   // Whole state of the main module.
   typedef struct packed {
      ve_state_t st;
      logic [31:0] ctrl;
      logic [31:0] excMap;
      logic [4:0] status;
      logic [4:0] mask;
      logic [15:0] exitReason;
      logic entryFail;
      logic mcEnSampled;
      logic [31:0] abortInd;
      logic [7:0] loadCnt;
      logic ack;
      logic [31:0] datO;
      logic irq;
      logic deliverHost;
      logic deliverGuest;
      logic exitDone;
   } ve_regs_t;

endpackage

// file: mc_route_decide.sv
// Chooses the treatment of a machine check from the current phase.
`timescale 1ns/100ps
`default_nettype none

module mc_route_decide
   import vmx_err_pkg::*;
(
   input wire logic mcEnable,
   input wire logic inVirtInstr,
   input wire logic inVmEntry,
   input wire logic entryGuestLoaded,
   input wire logic entryChecking,
   input wire logic inVmExit,
   input wire logic exitToRoot,
   input wire logic inGuest,
   input wire logic bitmapMcBit,
   input wire logic entryReloadPolicy,
   input wire logic exitAbortPolicy,
   output mc_action_t action
);

   // ----------------------------------------------------------------------
   // Treatment selection
   // ----------------------------------------------------------------------

   // Normal delivery in the current context, or shutdown when disabled outside guest, unless reload, abort or exit is chosen.
   always_comb begin
      if (inVirtInstr) begin
         action = mcEnable ? ACT_EXC_HOST : ACT_SHUT; // see [RULE3]
      end else if (inVmEntry) begin
         if (entryGuestLoaded) begin
            action = ACT_RELOAD; // see [RULE6]
         end else if (entryReloadPolicy) begin
            action = ACT_RELOAD; // see [RULE5]
         end else begin
            // Checking phase prefers delivery by default.
            action = mcEnable ? ACT_EXC_HOST : ACT_SHUT; // see [RULE4] [RULE7]
         end
      end else if (inVmExit) begin
         if (exitAbortPolicy && exitToRoot) begin
            action = ACT_ABORT; // see [RULE9]
         end else begin
            action = mcEnable ? ACT_EXC_GUEST : ACT_SHUT; // see [RULE8]
         end
      end else if (inGuest) begin
         // Any non-root action not yet judged to exit lands here.
         action = bitmapMcBit ? ACT_EXIT : ACT_EXC_GUEST; // see [RULE10] [RULE11]
      end else begin
         action = mcEnable ? ACT_EXC_HOST : ACT_SHUT;
      end
   end

endmodule

`default_nettype wire

// file: vmx_error_unit.sv
// Virtualization transition error and machine check handling unit.
//
// Functional notes
// [RULE1] VM exit loads and checks host state.
// [RULE2] Exit failures and machine checks cause abort.
// [RULE3] Enter/leave instruction: exception or shutdown.
// [RULE4] Entry: host table delivery or shutdown.
// [RULE5] Entry alternative: reload host, entry-failure reason.
// [RULE6] Guest state loaded forces host reload.
// [RULE7] During checks prefer delivery, reload allowed.
// [RULE8] Exit: guest table delivery or shutdown.
// [RULE9] Exit to root may abort, indicator marks check.
// [RULE10] Pre-decision non-root check counts as guest.
// [RULE11] Bitmap bit 12H: guest delivery or exit.
// [RULE12] Monitor treats saved guest state as suspect.
// [RULE13] Monitor parks target in wait-for-startup state.
// [RULE14] Enable bit sampled when check is recognised.
//
// The Wishbone slave port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "vmx_err_consts.svh"

module vmx_error_unit
   import vmx_err_pkg::*;
#(
   parameter int HOST_LOAD_CYCLES = `VE_HOST_LOAD_CYC,
   parameter logic [15:0] REASON_MC_EXCEPTION = 16'h0000,
   parameter logic [15:0] REASON_ENTRY_MC = 16'h0001,
   parameter logic [31:0] ABORT_CODE_MSR_STORE = 32'h0000_0001,
   parameter logic [31:0] ABORT_CODE_PAGE_DIR = 32'h0000_0002,
   parameter logic [31:0] ABORT_CODE_CORRUPT = 32'h0000_0003,
   parameter logic [31:0] ABORT_CODE_MSR_LOAD = 32'h0000_0004,
   parameter logic [31:0] ABORT_CODE_MC = 32'h0000_0005
)
(
   input wire logic clk,
   input wire logic rst,
   // Wishbone slave.
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   output logic irq,
   // Processor phase and events.
   input wire logic mcEvent,
   input wire logic inVirtInstr,
   input wire logic inVmEntry,
   input wire logic entryGuestLoaded,
   input wire logic entryChecking,
   input wire logic inVmExit,
   input wire logic exitToRoot,
   input wire logic inGuest,
   input wire logic exitReq,
   input wire logic [15:0] exitReasonIn,
   input wire logic guestMsrStoreFail,
   input wire logic pageDirLoadFail,
   input wire logic hostStateBad,
   input wire logic hostMsrLoadFail,
   // Actions towards the core.
   output logic mcDeliverHost,
   output logic mcDeliverGuest,
   output logic shutdownState,
   output logic hostLoadBusy,
   output logic exitDone,
   output logic [15:0] exitReason,
   output logic entryFailure,
   output logic virtAbort,
   output logic [31:0] abortIndicator
);

   localparam logic [7:0] LOAD_LAST = 8'(HOST_LOAD_CYCLES - 1);

   ve_regs_t r;
   ve_regs_t next_r;
   mc_action_t action;

   // Byte-enable merge of a write into a register.
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wdat,
                                         input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[i*8 +: 8] = wdat[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // ----------------------------------------------------------------------
   // Treatment decision
   // ----------------------------------------------------------------------

   // The enable bit is read live, so the choice follows its value at the
   // very cycle the check is recognised.
   mc_route_decide u_decide (
      .mcEnable(r.ctrl[`VE_CTRL_MCE]),
      .inVirtInstr(inVirtInstr),
      .inVmEntry(inVmEntry),
      .entryGuestLoaded(entryGuestLoaded),
      .entryChecking(entryChecking),
      .inVmExit(inVmExit),
      .exitToRoot(exitToRoot),
      .inGuest(inGuest),
      .bitmapMcBit(r.excMap[`VE_MC_VECTOR]),
      .entryReloadPolicy(r.ctrl[`VE_CTRL_ENTRY_RELOAD]),
      .exitAbortPolicy(r.ctrl[`VE_CTRL_EXIT_ABORT]),
      .action(action)
   );

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------

   always_comb begin
      logic [4:0] set;
      logic [7:0] a;
      set = '0;
      a = {adr_i[7:2], 2'b00};
      next_r = r;
      next_r.ack = 1'b0;
      next_r.deliverHost = 1'b0;
      next_r.deliverGuest = 1'b0;
      next_r.exitDone = 1'b0;

      // Bus access: one answer per request, then ack drops for a cycle.
      if (cyc_i && stb_i && !r.ack) begin
         next_r.ack = 1'b1;
         next_r.datO = 32'h0000_0000;
         if (we_i) begin
            if (a == `VE_REG_CTRL) begin
               next_r.ctrl = merge(r.ctrl, dat_i, sel_i);
            end else if (a == `VE_REG_EXCMAP) begin
               next_r.excMap = merge(r.excMap, dat_i, sel_i);
            end else if (a == `VE_REG_MASK) begin
               next_r.mask = 5'(merge({27'h0, r.mask}, dat_i, sel_i));
            end
         end else begin
            if (a == `VE_REG_CTRL) begin
               next_r.datO = r.ctrl;
            end else if (a == `VE_REG_EXCMAP) begin
               next_r.datO = r.excMap;
            end else if (a == `VE_REG_STATUS) begin
               next_r.datO = {27'h0, r.status};
               next_r.status = '0;
            end else if (a == `VE_REG_MASK) begin
               next_r.datO = {27'h0, r.mask};
            end else if (a == `VE_REG_EXITINFO) begin
               next_r.datO = {r.st, 2'b00, r.mcEnSampled, r.entryFail,
                              8'h00, r.exitReason};
            end else if (a == `VE_REG_ABORTIND) begin
               next_r.datO = r.abortInd;
            end
         end
      end

      // Recognised checks are logged along with the enable they met.
      if (mcEvent) begin
         set[`VE_ST_MCSEEN] = 1'b1;
         next_r.mcEnSampled = r.ctrl[`VE_CTRL_MCE]; // see [RULE14]
      end

      case (r.st)
         ST_IDLE: begin
            if (mcEvent) begin
               case (action)
                  ACT_EXC_HOST: begin
                     next_r.deliverHost = 1'b1; // see [RULE3] [RULE4]
                     set[`VE_ST_MCDELIVER] = 1'b1;
                  end
                  ACT_EXC_GUEST: begin
                     next_r.deliverGuest = 1'b1; // see [RULE8] [RULE11]
                     set[`VE_ST_MCDELIVER] = 1'b1;
                  end
                  ACT_SHUT: begin
                     next_r.st = ST_SHUT;
                     set[`VE_ST_SHUTDOWN] = 1'b1;
                  end
                  ACT_RELOAD: begin
                     next_r.st = ST_LOAD; // see [RULE5] [RULE6]
                     next_r.loadCnt = LOAD_LAST;
                     next_r.exitReason = REASON_ENTRY_MC;
                     next_r.entryFail = 1'b1;
                  end
                  ACT_ABORT: begin
                     next_r.st = ST_ABORT; // see [RULE9]
                     next_r.abortInd = ABORT_CODE_MC;
                     set[`VE_ST_ABORT] = 1'b1;
                  end
                  default: begin
                     // Bitmap routes the check into a VM exit.
                     next_r.st = ST_LOAD; // see [RULE11]
                     next_r.loadCnt = LOAD_LAST;
                     next_r.exitReason = REASON_MC_EXCEPTION;
                     next_r.entryFail = 1'b0;
                  end
               endcase
            end else if (exitReq) begin
               next_r.st = ST_LOAD; // see [RULE1]
               next_r.loadCnt = LOAD_LAST;
               next_r.exitReason = exitReasonIn;
               next_r.entryFail = 1'b0;
            end
         end
         ST_LOAD: begin
            // Host state is loaded and checked; any failure here cannot
            // be reported to software, so the exit turns into an abort.
            if (mcEvent || guestMsrStoreFail || pageDirLoadFail ||
                hostStateBad || hostMsrLoadFail) begin
               next_r.st = ST_ABORT; // see [RULE2]
               set[`VE_ST_ABORT] = 1'b1;
               if (mcEvent) begin
                  next_r.abortInd = ABORT_CODE_MC; // see [RULE9]
               end else if (guestMsrStoreFail) begin
                  next_r.abortInd = ABORT_CODE_MSR_STORE;
               end else if (pageDirLoadFail) begin
                  next_r.abortInd = ABORT_CODE_PAGE_DIR;
               end else if (hostStateBad) begin
                  next_r.abortInd = ABORT_CODE_CORRUPT; // see [RULE1]
               end else begin
                  next_r.abortInd = ABORT_CODE_MSR_LOAD;
               end
            end else if (r.loadCnt == 8'h00) begin
               next_r.st = ST_IDLE;
               next_r.exitDone = 1'b1;
               set[`VE_ST_EXITDONE] = 1'b1;
            end else begin
               next_r.loadCnt = r.loadCnt - 8'h01;
            end
         end
         ST_ABORT: begin
            // Abort blocks every further treatment until reset; checks still set VE_ST_MCSEEN.
            next_r.st = ST_ABORT; // see [RULE9]
         end
         ST_SHUT: begin
            next_r.st = ST_SHUT;
         end
         default: begin
            next_r.st = ST_IDLE;
         end
      endcase

      // Hardware set wins over a clearing read in the same cycle.
      next_r.status = next_r.status | set;
      next_r.irq = |(next_r.status & next_r.mask);
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------

   always_ff @(posedge clk) begin
      if (rst) begin
         r.st <= ST_IDLE;
         r.ctrl <= `VE_CTRL_RST;
         r.excMap <= `VE_EXCMAP_RST;
         r.status <= '0;
         r.mask <= 5'(`VE_MASK_RST);
         r.exitReason <= 16'h0000;
         r.entryFail <= 1'b0;
         r.mcEnSampled <= 1'b0;
         r.abortInd <= 32'h0000_0000;
         r.loadCnt <= 8'h00;
         r.ack <= 1'b0;
         r.datO <= 32'h0000_0000;
         r.irq <= 1'b0;
         r.deliverHost <= 1'b0;
         r.deliverGuest <= 1'b0;
         r.exitDone <= 1'b0;
      end else begin
         r <= next_r;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs, all straight from the state register
   // ----------------------------------------------------------------------

   assign dat_o = r.datO;
   assign ack_o = r.ack;
   assign irq = r.irq;
   assign mcDeliverHost = r.deliverHost;
   assign mcDeliverGuest = r.deliverGuest;
   assign shutdownState = (r.st == ST_SHUT);
   assign hostLoadBusy = (r.st == ST_LOAD);
   assign exitDone = r.exitDone;
   assign exitReason = r.exitReason;
   assign entryFailure = r.entryFail;
   assign virtAbort = (r.st == ST_ABORT);
   assign abortIndicator = r.abortInd;

endmodule

`default_nettype wire

// file: vmx_error_unit_asserts.sv
// Concurrent checks on the ports of the virtualization error unit.
`timescale 1ns/100ps
`default_nettype none

module vmx_error_unit_asserts #(
   parameter int HOST_LOAD_CYCLES = 4
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   input wire logic mcEvent,
   input wire logic inVirtInstr,
   input wire logic inVmEntry,
   input wire logic entryGuestLoaded,
   input wire logic inVmExit,
   input wire logic inGuest,
   input wire logic hostMsrLoadFail,
   input wire logic mcDeliverHost,
   input wire logic mcDeliverGuest,
   input wire logic shutdownState,
   input wire logic hostLoadBusy,
   input wire logic exitDone,
   input wire logic virtAbort,
   input wire logic [31:0] abortIndicator
);
   // ----------------------------------------------------------------
   // Helper logic
   // ----------------------------------------------------------------
   logic idle;
   logic [7:0] busyCnt;

   // Events are only taken while no load, abort or shutdown is pending.
   assign idle = !shutdownState && !virtAbort && !hostLoadBusy;

   // Counts the busy cycles, so the load length is checked exactly.
   always_ff @(posedge clk) begin
      if (rst || !hostLoadBusy) begin
         busyCnt <= 8'h00;
      end else begin
         busyCnt <= busyCnt + 8'h01;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_ack_one_cycle: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
      else $error("bus ack not a single cycle after request");
   a_instr_exc_or_shut: assert property (mcEvent && idle && inVirtInstr
      |=> mcDeliverHost != shutdownState)
      else $error("instruction machine check neither delivered nor shut");
   a_entry_loaded_reload: assert property (mcEvent && idle && !inVirtInstr
      && inVmEntry && entryGuestLoaded |=> hostLoadBusy && !mcDeliverHost)
      else $error("entry check after guest load not reloaded");
   a_exit_mc_treat: assert property (mcEvent && idle && !inVirtInstr
      && !inVmEntry && inVmExit |=> mcDeliverGuest || shutdownState || virtAbort)
      else $error("exit machine check without a treatment");
   a_guest_mc_route: assert property (mcEvent && idle && !inVirtInstr
      && !inVmEntry && !inVmExit && inGuest |=> mcDeliverGuest ^ hostLoadBusy)
      else $error("guest machine check not routed");
   a_load_length: assert property ($fell(hostLoadBusy) && !virtAbort
      |-> exitDone && busyCnt == HOST_LOAD_CYCLES)
      else $error("host load length or completion wrong");
   a_load_fail_abort: assert property (hostLoadBusy && (mcEvent || hostMsrLoadFail)
      |=> virtAbort && !exitDone)
      else $error("failure during host load did not abort");
   a_abort_blocks: assert property (virtAbort |=> virtAbort
      && $stable(abortIndicator) && !mcDeliverHost && !mcDeliverGuest)
      else $error("abort released or events not blocked");
   a_shut_holds: assert property (shutdownState |=> shutdownState && !mcDeliverHost)
      else $error("shutdown state left before reset");

   c_entry_mc: cover property (mcEvent && idle && inVmEntry);
   c_exit_done: cover property (exitDone);
   c_abort: cover property ($rose(virtAbort));
   c_shutdown: cover property ($rose(shutdownState));
endmodule

bind vmx_error_unit vmx_error_unit_asserts #(
   .HOST_LOAD_CYCLES(HOST_LOAD_CYCLES)
) u_chk (
   .clk(clk), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
   .mcEvent(mcEvent), .inVirtInstr(inVirtInstr), .inVmEntry(inVmEntry),
   .entryGuestLoaded(entryGuestLoaded), .inVmExit(inVmExit),
   .inGuest(inGuest), .hostMsrLoadFail(hostMsrLoadFail),
   .mcDeliverHost(mcDeliverHost), .mcDeliverGuest(mcDeliverGuest),
   .shutdownState(shutdownState), .hostLoadBusy(hostLoadBusy),
   .exitDone(exitDone), .virtAbort(virtAbort),
   .abortIndicator(abortIndicator)
);
`default_nettype wire

// file: core_phase_model.sv
// Stand-in for the core and its monitor: phase levels and check pulses.
`timescale 1ns/100ps
`default_nettype none

module core_phase_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic go,
   input wire logic [2:0] kind,
   output logic mcEvent,
   output logic inVirtInstr,
   output logic inVmEntry,
   output logic entryGuestLoaded,
   output logic entryChecking,
   output logic inVmExit,
   output logic exitToRoot,
   output logic inGuest
);
   // One request gives one check pulse with its phase levels beside it.
   // Phases drop afterwards, so a stale phase never qualifies a pulse.
   // An idle kind stands for a processor parked awaiting startup.
   always_ff @(posedge clk) begin
      mcEvent <= go && !rst;
      inVirtInstr <= go && kind == 3'h0;
      inVmEntry <= go && (kind == 3'h1 || kind == 3'h2);
      entryGuestLoaded <= go && kind == 3'h1;
      entryChecking <= go && kind == 3'h2;
      inVmExit <= go && (kind == 3'h3 || kind == 3'h4);
      exitToRoot <= go && kind == 3'h4;
      inGuest <= go && kind == 3'h5;
   end
endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking testbench of the virtualization error unit.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
   logic clk, rst, cyc_i, stb_i, we_i, ack_o, irq, go, exitReq;
   logic hostMsrLoadFail, mcEvent, inVirtInstr, inVmEntry;
   logic entryGuestLoaded, entryChecking, inVmExit, exitToRoot, inGuest;
   logic mcDeliverHost, mcDeliverGuest, shutdownState, hostLoadBusy;
   logic exitDone, entryFailure, virtAbort;
   logic [7:0] adr_i;
   logic [31:0] dat_i, dat_o, abortIndicator, rdData;
   logic [15:0] exitReasonIn, exitReason;
   logic [2:0] kind;
   int miscompares = 0;
   int cmp_count = 0;

   // ----------------------------------------------------------------
   // Clock, design and core stand-in
   // ----------------------------------------------------------------
   always #25 clk = ~clk;

   vmx_error_unit DUT (
      .clk(clk), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .irq(irq), .mcEvent(mcEvent),
      .inVirtInstr(inVirtInstr), .inVmEntry(inVmEntry),
      .entryGuestLoaded(entryGuestLoaded), .entryChecking(entryChecking),
      .inVmExit(inVmExit), .exitToRoot(exitToRoot), .inGuest(inGuest),
      .exitReq(exitReq), .exitReasonIn(exitReasonIn),
      .guestMsrStoreFail(1'b0), .pageDirLoadFail(1'b0),
      .hostStateBad(1'b0), .hostMsrLoadFail(hostMsrLoadFail),
      .mcDeliverHost(mcDeliverHost), .mcDeliverGuest(mcDeliverGuest),
      .shutdownState(shutdownState), .hostLoadBusy(hostLoadBusy),
      .exitDone(exitDone), .exitReason(exitReason),
      .entryFailure(entryFailure), .virtAbort(virtAbort),
      .abortIndicator(abortIndicator));

   core_phase_model u_core (
      .clk(clk), .rst(rst), .go(go), .kind(kind), .mcEvent(mcEvent),
      .inVirtInstr(inVirtInstr), .inVmEntry(inVmEntry),
      .entryGuestLoaded(entryGuestLoaded), .entryChecking(entryChecking),
      .inVmExit(inVmExit), .exitToRoot(exitToRoot), .inGuest(inGuest));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One classic cycle; the request holds until ack is sampled high.
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      // Only the watchdog ends a wait that never sees ack.
      do begin
         @(posedge clk);
      end while (ack_o !== 1'b1);
      rdData = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      @(posedge clk);
   endtask

   task automatic resetDut();
      rst <= 1'b1;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
   endtask

   // Ends at the falling edge after the unit has taken the check.
   task automatic fireMc(input logic [2:0] k);
      kind <= k;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      @(negedge clk);
   endtask

   task automatic startExit(input logic [15:0] r);
      exitReq <= 1'b1;
      exitReasonIn <= r;
      @(posedge clk);
      exitReq <= 1'b0;
      @(negedge clk);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_regs();
      resetDut();
      wb(1'b0, 8'h00, 32'h0);
      chk("ctrl reset", 32'h0, rdData);
      wb(1'b1, 8'h1C, 32'hFFFF_FFFF);
      wb(1'b0, 8'h1C, 32'h0);
      chk("unmapped read", 32'h0, rdData);
      wb(1'b1, 8'h10, 32'hFFFF_FFFF);
      wb(1'b0, 8'h10, 32'h0);
      chk("exit info idle", 32'h1000_0000, rdData);
   endtask

   // Enable bit decides exception or shutdown at the moment of the check.
   task automatic t_virt();
      for (int e = 0; e < 2; e++) begin
         resetDut();
         wb(1'b1, 8'h00, 32'(e));
         fireMc(3'h0);
         chk("deliver host", 32'(e), {31'h0, mcDeliverHost});
         chk("shutdown", 32'(1 - e), {31'h0, shutdownState});
         @(posedge clk);
      end
   endtask

   task automatic t_entry();
      resetDut();
      wb(1'b1, 8'h00, 32'h1);
      fireMc(3'h2);
      chk("check phase deliver", 32'h1, {31'h0, mcDeliverHost});
      @(posedge clk);
      wb(1'b1, 8'h00, 32'h3);
      fireMc(3'h2);
      chk("check phase reload", 32'h1, {31'h0, hostLoadBusy});
      repeat (6) @(posedge clk);
      fireMc(3'h1);
      chk("loaded reload", 32'h1, {31'h0, hostLoadBusy});
      chk("entry failure", 32'h1, {31'h0, entryFailure});
      chk("entry reason", 32'h1, {16'h0, exitReason});
      repeat (6) @(posedge clk);
      wb(1'b1, 8'h00, 32'h0);
      fireMc(3'h2);
      chk("entry shutdown", 32'h1, {31'h0, shutdownState});
      @(posedge clk);
   endtask

   task automatic t_exit();
      resetDut();
      wb(1'b1, 8'h0C, 32'h8);
      startExit(16'h00AB);
      chk("load busy", 32'h1, {31'h0, hostLoadBusy});
      chk("exit reason", 32'hAB, {16'h0, exitReason});
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk("exit done", 32'h1, {31'h0, exitDone});
      chk("busy cleared", 32'h0, {31'h0, hostLoadBusy});
      @(posedge clk);
      @(negedge clk);
      chk("irq raised", 32'h1, {31'h0, irq});
      @(posedge clk);
      wb(1'b0, 8'h08, 32'h0);
      chk("status", 32'h8, rdData);
      @(negedge clk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      @(posedge clk);
      startExit(16'h0001);
      @(posedge clk);
      hostMsrLoadFail <= 1'b1;
      @(posedge clk);
      hostMsrLoadFail <= 1'b0;
      @(negedge clk);
      chk("abort", 32'h1, {31'h0, virtAbort});
      chk("abort code", 32'h4, abortIndicator);
      @(posedge clk);
      fireMc(3'h0);
      chk("blocked", 32'h0, {31'h0, mcDeliverHost});
      @(posedge clk);
   endtask

   task automatic t_exit_mc();
      resetDut();
      wb(1'b1, 8'h00, 32'h1);
      fireMc(3'h3);
      chk("exit deliver", 32'h1, {31'h0, mcDeliverGuest});
      @(posedge clk);
      wb(1'b1, 8'h00, 32'h5);
      fireMc(3'h4);
      chk("exit abort", 32'h1, {31'h0, virtAbort});
      chk("mc abort code", 32'h5, abortIndicator);
      @(posedge clk);
   endtask

   task automatic t_guest();
      resetDut();
      wb(1'b1, 8'h04, 32'h0);
      fireMc(3'h5);
      chk("guest deliver", 32'h1, {31'h0, mcDeliverGuest});
      // A plain exit first, so the machine check reason must overwrite it.
      startExit(16'h0055);
      repeat (6) @(posedge clk);
      wb(1'b1, 8'h04, 32'h0004_0000);
      fireMc(3'h5);
      chk("guest exit", 32'h1, {31'h0, hostLoadBusy});
      chk("guest reason", 32'h0, {16'h0, exitReason});
      repeat (6) @(posedge clk);
      wb(1'b0, 8'h08, 32'h0);
      chk("mc seen", 32'h10, rdData & 32'h10);
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      {cyc_i, stb_i, we_i, go, exitReq, hostMsrLoadFail} = 6'h00;
      adr_i = 8'h00;
      dat_i = 32'h0;
      exitReasonIn = 16'h0;
      kind = 3'h6;
      t_regs();
      t_virt();
      t_entry();
      t_exit();
      t_exit_mc();
      t_guest();
      report_and_stop();
   end

   // The tests need well under a thousand cycles; this allows far more.
   initial begin
      #1000000;
      miscompares++;
      report_and_stop();
   end
endmodule
`default_nettype wire
